// file: logic/e1ja_top.sv
`timescale 1ns/10ps
module e1ja_top
  import e1ja_pkg::*;
#(
  parameter int          OVERSAMPLE  = 32,
  parameter logic [7:0]  LOSS_BITS   = 8'hFF,
  parameter logic [7:0]  ALT_GAP_MAX = 8'h40
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        RX_LINE_POS,
  input  wire logic        RX_LINE_NEG,
  input  wire logic        ALT_CLOCK_IN,
  input  wire logic        TX_CLOCK_IN,
  input  wire logic        TX_DATA_IN,
  input  wire logic        CRYSTAL_PIN_A,
  output logic             CRYSTAL_LOAD_FAST,
  output logic             RECOVERED_CLOCK_OUT,
  output logic             RX_DATA_OUT,
  output logic             CARRIER_LOSS,
  output logic             TX_LINE_POS,
  output logic             TX_LINE_NEG,
  output logic      [2:0]  BUILD_OUT_SEL
);
  if (OVERSAMPLE != 32) $error("Recovery is built for 32 samples per bit");

  logic [7:0] ctrl_r;
  logic       trip_r;
  logic       ack_r;
  logic [7:0] rdata;
  logic       req;
  logic       mark_r;
  logic       mark_d_r;
  logic [4:0] phase_r;
  logic       seen_r;
  logic       rec_tick_r;
  logic       rec_bit_r;
  logic [7:0] zero_r;
  logic       alt_d_r;
  logic [7:0] alt_gap_r;
  logic       alt_ok_r;
  logic       tx_d_r;
  logic       xtal_d_r;
  logic       pol_r;
  logic [3:0] pulse_r;
  logic       ja_side;
  logic       ja_depth32;
  logic       ja_off;
  logic       ja_rx;
  logic       ja_tx;
  logic       rec_clk;
  logic       alt_rise;
  logic       tx_rise;
  logic       src_tick;
  logic       src_bit;
  logic       wr_tick;
  logic       wr_bit;
  logic       center;
  logic       rd_clk;
  logic       rd_tick;
  logic       rd_bit;
  logic       trip;
  logic       pull_fast;
  logic       tx_tick;
  logic       tx_bit;
  logic       rclk_nxt;

  assign ja_side    = ctrl_r[BIT_SIDE];
  assign ja_depth32 = ctrl_r[BIT_DEPTH];
  assign ja_off     = ctrl_r[BIT_DISABLE];
  assign ja_rx      = !ja_off && !ja_side;
  assign ja_tx      = !ja_off && ja_side;
  assign req        = WB_CYC_I && WB_STB_I && !ack_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ack_r <= 1'b0;
    else if (CE) ack_r <= req;
  end

  // Only the low byte lane holds register bits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ctrl_r <= CTRL_RESET;
    else if (CE && req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADR_LINE_CTRL) ctrl_r <= WB_DAT_I[7:0];
  end

  // Trip is sticky until read; a new trip in the read cycle wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) trip_r <= 1'b0;
    else if (CE) begin
      if (trip) trip_r <= 1'b1;
      else if (req && !WB_WE_I && WB_ADR_I == ADR_RX_INFO) trip_r <= 1'b0;
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (WB_ADR_I == ADR_LINE_CTRL) rdata = ctrl_r;
    else if (WB_ADR_I == ADR_RX_INFO) begin
      rdata[BIT_TRIP] = trip_r;
      rdata[BIT_LOSS] = CARRIER_LOSS;
      rdata[BIT_ALT]  = alt_ok_r;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) WB_DAT_O <= 32'h0000_0000;
    else if (CE && req) WB_DAT_O <= {24'h00_0000, rdata};
  end

  assign WB_ACK_O = ack_r;

  // Each CLK is one of 32 samples per unit interval; the x4 crystal PLL is off-block
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mark_r   <= 1'b0;
      mark_d_r <= 1'b0;
      phase_r  <= 5'h00;
    end else if (CE) begin
      mark_r   <= RX_LINE_POS || RX_LINE_NEG;
      mark_d_r <= mark_r;
      if (mark_r && !mark_d_r) phase_r <= OS_CENTER;
      else phase_r <= phase_r + 5'h01;
    end
  end

  // Recovered clock only; its high phase shifts when a mark realigns the phase
  assign rec_clk = phase_r < OS_CENTER;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seen_r     <= 1'b0;
      rec_tick_r <= 1'b0;
      rec_bit_r  <= 1'b0;
    end else if (CE) begin
      rec_tick_r <= phase_r == OS_LAST;
      if (phase_r == OS_LAST) begin
        rec_bit_r <= seen_r || mark_r;
        seen_r    <= mark_r;
      end else if (mark_r) seen_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      zero_r       <= 8'h00;
      CARRIER_LOSS <= 1'b1;
    end else if (CE) begin
      if (mark_r) begin
        zero_r       <= 8'h00;
        CARRIER_LOSS <= 1'b0;
      end else if (rec_tick_r && zero_r != LOSS_BITS) zero_r <= zero_r + 8'h01;
      else if (zero_r == LOSS_BITS) CARRIER_LOSS <= 1'b1;
    end
  end

  assign alt_rise = ALT_CLOCK_IN && !alt_d_r;
  assign tx_rise  = TX_CLOCK_IN && !tx_d_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      alt_d_r   <= 1'b0;
      alt_gap_r <= 8'h00;
      alt_ok_r  <= 1'b0;
    end else if (CE) begin
      alt_d_r <= ALT_CLOCK_IN;
      if (alt_rise) alt_gap_r <= 8'h00;
      else if (alt_gap_r != ALT_GAP_MAX) alt_gap_r <= alt_gap_r + 8'h01;
      alt_ok_r <= alt_gap_r != ALT_GAP_MAX;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_d_r   <= 1'b0;
      xtal_d_r <= 1'b0;
    end else if (CE) begin
      tx_d_r   <= TX_CLOCK_IN;
      xtal_d_r <= CRYSTAL_PIN_A;
    end
  end

  // Receive source: line when present, else alt clock with all-zero data
  assign src_tick = CARRIER_LOSS ? (alt_ok_r && alt_rise) : rec_tick_r;
  assign src_bit  = CARRIER_LOSS ? 1'b0 : rec_bit_r;
  assign wr_tick  = ja_rx ? src_tick : (ja_tx && tx_rise);
  assign wr_bit   = ja_rx ? src_bit : TX_DATA_IN;
  assign center   = CARRIER_LOSS && !alt_ok_r && !ja_tx;

  e1ja_buffer #(
    .DEPTH_MAX (128)
  ) u_buffer (
    .clk       (CLK),
    .rst       (RST),
    .ce        (CE),
    .wr_tick   (wr_tick),
    .wr_bit    (wr_bit),
    .depth32   (ja_depth32),
    .center    (center),
    .xtal_edge (CRYSTAL_PIN_A != xtal_d_r),
    .rd_clk    (rd_clk),
    .rd_tick   (rd_tick),
    .rd_bit    (rd_bit),
    .trip      (trip),
    .pull_fast (pull_fast)
  );

  always_comb begin
    rclk_nxt = rec_clk;
    if (ja_rx) rclk_nxt = rd_clk;
    else if (CARRIER_LOSS && alt_ok_r) rclk_nxt = ALT_CLOCK_IN;
    else if (CARRIER_LOSS) rclk_nxt = rd_clk;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RECOVERED_CLOCK_OUT <= 1'b0;
      RX_DATA_OUT         <= 1'b0;
      CRYSTAL_LOAD_FAST   <= 1'b0;
      BUILD_OUT_SEL       <= 3'h0;
    end else if (CE) begin
      RECOVERED_CLOCK_OUT <= rclk_nxt;
      RX_DATA_OUT         <= ja_rx ? rd_bit : src_bit;
      CRYSTAL_LOAD_FAST   <= !ja_off && pull_fast;
      BUILD_OUT_SEL       <= ctrl_r[BIT_BUILD_LO +: 3];
    end
  end

  // The tx clock edge starts a pulse, or the buffer read tick when ja_tx puts the attenuator in the transmit path; width is counted here
  assign tx_tick = ja_tx ? rd_tick : tx_rise;
  assign tx_bit  = ja_tx ? rd_bit : TX_DATA_IN;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pol_r       <= 1'b0;
      pulse_r     <= 4'h0;
      TX_LINE_POS <= 1'b0;
      TX_LINE_NEG <= 1'b0;
    end else if (CE) begin
      if (tx_tick && tx_bit) begin
        pulse_r     <= 4'(TX_PULSE_CYC - 1);
        TX_LINE_POS <= !pol_r;
        TX_LINE_NEG <= pol_r;
        pol_r       <= !pol_r;
      end else if (pulse_r != 4'h0) pulse_r <= pulse_r - 4'h1;
      else begin
        TX_LINE_POS <= 1'b0;
        TX_LINE_NEG <= 1'b0;
      end
    end
  end

  default clocking @(posedge CLK iff CE); endclocking
  default disable iff (RST);
  sequence s_req_wait;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  property p_ack;
    s_req_wait |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("Wishbone ack not a single cycle after request");
  property p_loss_set;
    (zero_r == LOSS_BITS && !mark_r) |=> CARRIER_LOSS;
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("Carrier loss not raised");
  property p_alt_direct;
    (ja_tx && CARRIER_LOSS && alt_ok_r) |=> RECOVERED_CLOCK_OUT == $past(ALT_CLOCK_IN);
  endproperty
  a_alt_direct: assert property (p_alt_direct) else $error("Alt clock not passed directly");
  property p_alt_ok;
    alt_rise |=> ##1 alt_ok_r;
  endproperty
  a_alt_ok: assert property (p_alt_ok) else $error("Alt clock not detected");
  property p_line_clk;
    (!ja_rx && !CARRIER_LOSS) |=> RECOVERED_CLOCK_OUT == $past(rec_clk);
  endproperty
  a_line_clk: assert property (p_line_clk) else $error("Recovered clock not from line");
  property p_build;
    ##1 BUILD_OUT_SEL == $past(ctrl_r[7:5]);
  endproperty
  a_build: assert property (p_build) else $error("Build-out select not following control");
  property p_trip_seen;
    trip |=> trip_r;
  endproperty
  a_trip_seen: assert property (p_trip_seen) else $error("Limit trip not recorded");
  sequence s_pulse_start;
    tx_tick && tx_bit && !ja_tx;
  endsequence
  property p_pulse;
    s_pulse_start |=> (TX_LINE_POS || TX_LINE_NEG) [*4];
  endproperty
  a_pulse: assert property (p_pulse) else $error("Transmit pulse shorter than its width");
  // Without the attenuator in the receive path data leaves unbuffered
  property p_rx_bypass;
    !ja_rx |=> RX_DATA_OUT == $past(src_bit);
  endproperty
  a_rx_bypass: assert property (p_rx_bypass) else $error("Receive data not bypassing attenuator");
  property p_loss_clear;
    mark_r |=> !CARRIER_LOSS;
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("Carrier loss kept despite a mark");
endmodule

// file: logic/e1ja_pkg.sv
package e1ja_pkg;
  localparam int          CLK_MHZ        = 20;
  localparam int          TX_PULSE_NS    = 244;
  localparam int          TX_PULSE_CYC   = (TX_PULSE_NS * CLK_MHZ) / 1000;
  localparam logic [7:0]  ADR_LINE_CTRL  = 8'h18;
  localparam logic [7:0]  ADR_RX_INFO    = 8'h1C;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          BIT_BUILD_LO   = 5;
  localparam int          BIT_SIDE       = 3;
  localparam int          BIT_DEPTH      = 2;
  localparam int          BIT_DISABLE    = 1;
  localparam int          BIT_TRIP       = 5;
  localparam int          BIT_LOSS       = 0;
  localparam int          BIT_ALT        = 1;
  localparam logic [4:0]  OS_CENTER      = 5'h10;
  localparam logic [4:0]  OS_LAST        = 5'h1F;
  localparam logic [3:0]  HALF_NORM      = 4'h8;
  localparam logic [3:0]  HALF_FAST      = 4'h7;
  localparam logic [3:0]  HALF_SLOW      = 4'h9;
  localparam logic [7:0]  DEPTH_SMALL    = 8'h20;
  localparam logic [7:0]  DEPTH_LARGE    = 8'h80;
  localparam logic [7:0]  MARGIN_SMALL   = 8'h02;
  localparam logic [7:0]  MARGIN_LARGE   = 8'h04;
endpackage

// file: logic/e1ja_buffer.sv
`timescale 1ns/10ps
module e1ja_buffer
  import e1ja_pkg::*;
#(
  parameter int DEPTH_MAX = 128
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic wr_tick,
  input  wire logic wr_bit,
  input  wire logic depth32,
  input  wire logic center,
  input  wire logic xtal_edge,
  output logic      rd_clk,
  output logic      rd_tick,
  output logic      rd_bit,
  output logic      trip,
  output logic      pull_fast
);
  if (DEPTH_MAX != 128) $error("Buffer needs DEPTH_MAX of 128");

  logic       mem [DEPTH_MAX];
  logic [6:0] wptr_r;
  logic [6:0] rptr_r;
  logic [7:0] fill_r;
  logic [3:0] half_r;
  logic [3:0] lim;
  logic [7:0] depth;
  logic [7:0] margin;
  logic [6:0] mask;
  logic       do_wr;
  logic       do_rd;

  assign depth  = depth32 ? DEPTH_SMALL : DEPTH_LARGE;
  assign margin = depth32 ? MARGIN_SMALL : MARGIN_LARGE;
  assign mask   = 7'(depth - 8'h01);
  // Too full reads faster, too empty reads slower; centered always divides by 4
  always_comb begin
    lim = HALF_NORM;
    if (!center && fill_r > depth - margin) lim = HALF_FAST;
    else if (!center && fill_r < margin) lim = HALF_SLOW;
  end
  assign do_rd = xtal_edge && half_r == lim - 4'h1 && !center;
  assign do_wr = wr_tick && fill_r < depth;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) half_r <= 4'h0;
    else if (ce && xtal_edge) half_r <= (half_r >= lim - 4'h1) ? 4'h0 : half_r + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (ce && do_wr) mem[wptr_r] <= wr_bit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_r <= 7'h00;
      rptr_r <= 7'h00;
      fill_r <= 8'h00;
    end else if (ce) begin
      if (do_wr) wptr_r <= (wptr_r + 7'h01) & mask;
      if (do_rd && fill_r != 8'h00) rptr_r <= (rptr_r + 7'h01) & mask;
      fill_r <= fill_r + {7'h00, do_wr} - {7'h00, do_rd && fill_r != 8'h00};
    end
  end

  // Read clock is high for the first half of each divide: near 50% duty
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_clk    <= 1'b0;
      rd_tick   <= 1'b0;
      rd_bit    <= 1'b0;
      trip      <= 1'b0;
      pull_fast <= 1'b0;
    end else if (ce) begin
      rd_clk    <= half_r < (lim >> 1);
      rd_tick   <= do_rd;
      if (do_rd) rd_bit <= (fill_r != 8'h00) ? mem[rptr_r] : 1'b0;
      trip      <= lim != HALF_NORM;
      pull_fast <= fill_r > (depth >> 1);
    end
  end

  default clocking @(posedge clk iff ce); endclocking
  default disable iff (rst);
  property p_no_overflow;
    fill_r <= depth;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("Buffer fill above depth");
  property p_trip_div;
    ##1 (trip == ($past(lim) != HALF_NORM));
  endproperty
  a_trip_div: assert property (p_trip_div) else $error("Trip flag does not match divide");
  property p_center_norm;
    center |-> lim == HALF_NORM && !do_rd;
  endproperty
  a_center_norm: assert property (p_center_norm) else $error("Centered crystal not divided by 4");
endmodule

// file: dv/e1ja_line_model.sv
`timescale 1ns/10ps
module e1ja_line_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       line_on,
  input  wire logic       alt_on,
  input  wire logic [3:0] xhalf,
  input  wire logic [4:0] tx_high,
  output logic            rx_pos,
  output logic            rx_neg,
  output logic            alt_clk,
  output logic            tx_clk,
  output logic            xtal
);
  logic [4:0] ph_r;
  logic [2:0] alt_r;
  logic [3:0] xc_r;
  logic       pol_r;
  // All-ones AMI, one bit per 32 clk, half-width marks of alternating polarity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_r   <= 5'h00;
      pol_r  <= 1'b0;
      rx_pos <= 1'b0;
      rx_neg <= 1'b0;
      tx_clk <= 1'b0;
    end else begin
      ph_r   <= ph_r + 5'h01;
      rx_pos <= line_on & (ph_r < 5'h10) & pol_r;
      rx_neg <= line_on & (ph_r < 5'h10) & ~pol_r;
      tx_clk <= (ph_r < tx_high);
      if (ph_r == 5'h1F) begin
        pol_r <= ~pol_r;
      end
    end
  end
  // Absent alternate clock is tied low, never left floating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alt_r   <= 3'h0;
      alt_clk <= 1'b0;
    end else begin
      alt_r <= alt_r + 3'h1;
      if (!alt_on) begin
        alt_clk <= 1'b0;
      end else if (alt_r == 3'h7) begin
        alt_clk <= ~alt_clk;
      end
    end
  end
  // Crystal half period in clk cycles; 4 matches the line rate after divide by 4
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xc_r <= 4'h0;
      xtal <= 1'b0;
    end else if (xc_r >= xhalf - 4'h1) begin
      xc_r <= 4'h0;
      xtal <= ~xtal;
    end else begin
      xc_r <= xc_r + 4'h1;
    end
  end
endmodule

// file: dv/e1ja_tb_top.sv
`timescale 1ns/10ps
module e1ja_tb_top;
  import e1ja_pkg::*;
  logic        clk, rst, ce, cyc, stb, we, ack, tx_data, line_on, alt_on;
  logic        rxp, rxn, altc, txc, xtal, ldf, rco, rxd, cl, txp, txn;
  logic [7:0]  adr;
  logic [3:0]  sel, xhalf;
  logic [4:0]  tx_high;
  logic [31:0] dati, dato, q;
  logic [2:0]  bsel;
  logic        rc_q;
  int          err_total, checks, rc_rise, rc_high, tp_cyc, tn_cyc, t_both, i;
  logic [7:0]  rows [8] = '{8'h00, 8'h32, 8'h44, 8'h76, 8'h88, 8'hBA, 8'hCC, 8'hFF};
  logic [2:0]  exp_b [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};

  e1ja_top #(.LOSS_BITS(8'h08)) dut_u (.CLK(clk), .RST(rst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack),
    .RX_LINE_POS(rxp), .RX_LINE_NEG(rxn), .ALT_CLOCK_IN(altc), .TX_CLOCK_IN(txc), .TX_DATA_IN(tx_data),
    .CRYSTAL_PIN_A(xtal), .CRYSTAL_LOAD_FAST(ldf), .RECOVERED_CLOCK_OUT(rco), .RX_DATA_OUT(rxd),
    .CARRIER_LOSS(cl), .TX_LINE_POS(txp), .TX_LINE_NEG(txn), .BUILD_OUT_SEL(bsel));
  e1ja_line_model line_u (.clk(clk), .rst(rst), .line_on(line_on), .alt_on(alt_on), .xhalf(xhalf),
    .tx_high(tx_high), .rx_pos(rxp), .rx_neg(rxn), .alt_clk(altc), .tx_clk(txc), .xtal(xtal));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Monitors sample on the falling edge, away from the design's updates
  always @(negedge clk) begin
    if (rco && !rc_q) rc_rise++;
    rc_q = rco;
    if (rco) rc_high++;
    if (txp) tp_cyc++;
    if (txn) tn_cyc++;
    if (txp && txn) t_both++;
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("ERROR %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Classic single cycle: hold until ack seen, release at the edge that samples it
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dati <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk_bit(1'b0, 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic window(input int n);
    @(posedge clk);
    rc_rise = 0;
    rc_high = 0;
    tp_cyc = 0;
    tn_cyc = 0;
    t_both = 0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_loss(input logic exp, input int max);
    int n;
    n = 0;
    while (cl !== exp && n < max) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk_bit(cl, 1'b1);
    chk_reg({ack, rco, ldf, txp, txn, bsel}, 32'h00000000);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    {rst, ce, cyc, stb, we, line_on, alt_on} = 7'b1100000;
    {adr, sel, dati, tx_data} = '0;
    xhalf = 4'h4;
    tx_high = 5'h10;
    do_reset;
    end_test("reset");
    for (i = 0; i < 8; i++) begin
      wb(1'b1, ADR_LINE_CTRL, 4'hF, rows[i]);
      wb(1'b0, ADR_LINE_CTRL, 4'hF, 8'h00);
      chk_reg(q, {24'h000000, rows[i]});
      chk_reg({29'h0, bsel}, {29'h0, exp_b[i]});
    end
    end_test("control rows");
    wb(1'b1, ADR_LINE_CTRL, 4'hE, 8'h00);
    wb(1'b0, ADR_LINE_CTRL, 4'hF, 8'h00);
    chk_reg(q, 32'h000000FF);
    wb(1'b0, 8'h40, 4'hF, 8'h00);
    chk_reg(q, 32'h00000000);
    wb(1'b1, ADR_LINE_CTRL, 4'hF, 8'h00);
    end_test("bus refusals");
    line_on <= 1'b1;
    wait_loss(1'b0, 300);
    chk_bit(cl, 1'b0);
    // The buffer starts empty and reads at 4.5 until its fill passes the margin
    repeat (2000) @(posedge clk);
    window(512);
    chk_rng(rc_rise, 15, 17);
    chk_rng(rc_high, 224, 288);
    chk_bit(rxd, 1'b1);
    wb(1'b0, ADR_RX_INFO, 4'hF, 8'h00);
    chk_bit(q[BIT_LOSS], 1'b0);
    end_test("line present");
    // Slow crystal fills the 32-bit buffer; fast crystal drains it
    wb(1'b1, ADR_LINE_CTRL, 4'hF, 8'h04);
    xhalf <= 4'h5;
    repeat (1000) @(posedge clk);
    wb(1'b0, ADR_RX_INFO, 4'hF, 8'h00);
    repeat (5000) @(posedge clk);
    chk_bit(ldf, 1'b1);
    wb(1'b0, ADR_RX_INFO, 4'hF, 8'h00);
    chk_bit(q[BIT_TRIP], 1'b1);
    xhalf <= 4'h3;
    repeat (2000) @(posedge clk);
    chk_bit(ldf, 1'b0);
    xhalf <= 4'h4;
    end_test("crystal pull and trip");
    wb(1'b1, ADR_LINE_CTRL, 4'hF, 8'h02);
    window(512);
    chk_rng(rc_rise, 15, 17);
    chk_bit(rxd, 1'b1);
    chk_bit(ldf, 1'b0);
    end_test("attenuator disabled");
    wb(1'b1, ADR_LINE_CTRL, 4'hF, 8'h08);
    alt_on <= 1'b1;
    line_on <= 1'b0;
    wait_loss(1'b1, 400);
    chk_bit(cl, 1'b1);
    wb(1'b0, ADR_RX_INFO, 4'hF, 8'h00);
    chk_reg({30'h0, q[BIT_ALT], q[BIT_LOSS]}, 32'h00000003);
    window(512);
    chk_rng(rc_rise, 31, 33);
    chk_bit(rxd, 1'b0);
    end_test("loss with alt");
    alt_on <= 1'b0;
    wb(1'b1, ADR_LINE_CTRL, 4'hF, 8'h00);
    repeat (200) @(posedge clk);
    wb(1'b0, ADR_RX_INFO, 4'hF, 8'h00);
    chk_bit(q[BIT_ALT], 1'b0);
    window(512);
    chk_rng(rc_rise, 15, 17);
    wb(1'b1, ADR_LINE_CTRL, 4'hF, 8'h08);
    repeat (1500) @(posedge clk);
    window(512);
    chk_rng(rc_rise, 15, 17);
    wb(1'b1, ADR_LINE_CTRL, 4'hF, 8'h00);
    end_test("loss without alt");
    tx_data <= 1'b1;
    for (i = 0; i < 2; i++) begin
      tx_high <= (i == 0) ? 5'h04 : 5'h1C;
      @(negedge clk);
      while (txc !== 1'b0) @(negedge clk);
      while (txc !== 1'b1) @(negedge clk);
      window(256);
      chk_rng(tp_cyc, 16, 16);
      chk_rng(tn_cyc, 16, 16);
      chk_rng(t_both, 0, 0);
    end
    end_test("tx duty");
    // Clock enable low must freeze every output although the pins keep moving
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    q = {22'h0, rco, cl, rxd, ldf, txp, txn, ack, bsel};
    repeat (100) @(posedge clk);
    @(negedge clk);
    chk_reg({22'h0, rco, cl, rxd, ldf, txp, txn, ack, bsel}, q);
    @(posedge clk);
    ce <= 1'b1;
    end_test("clock enable");
    wb(1'b1, ADR_LINE_CTRL, 4'hF, 8'hA6);
    do_reset;
    wb(1'b0, ADR_LINE_CTRL, 4'hF, 8'h00);
    chk_reg(q, {24'h000000, CTRL_RESET});
    end_test("second reset");
    report_and_stop;
  end
endmodule
